// ===== rtl/gcr_params.svh
`ifndef GCR_PARAMS_SVH
`define GCR_PARAMS_SVH

`define GCR_CFG_ADDR      7'h00
`define GCR_WR_FLAG       8'h80
`define GCR_CFG_W         10
`define GCR_CFG_RESET     10'h101
`define GCR_OTP_MASK      10'h006
`define GCR_B_VREF        0
`define GCR_B_RSENSE      1
`define GCR_B_CHOP        2
`define GCR_B_SHAFT       3
`define GCR_B_IDX_OTPW    4
`define GCR_B_IDX_STEP    5
`define GCR_B_PDN_DIS     6
`define GCR_B_MSTEP_REG   7
`define GCR_B_FILT        8
`define GCR_B_TEST        9

`endif

// ===== rtl/gcr_pkg.sv
`include "gcr_params.svh"

package gcr_pkg;

	typedef enum logic [1:0] {
		GCR_IDX_FIRST_POS,
		GCR_IDX_OTPW,
		GCR_IDX_STEP
	} gcr_index_src_e;

	typedef logic [`GCR_CFG_W-1:0] gcr_cfg_t;

endpackage : gcr_pkg

// ===== rtl/gcr_sync.sv
`timescale 1ns/1ns
`default_nettype none

module gcr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// First stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : gcr_sync

`default_nettype wire

// ===== rtl/gcr_index.sv
`timescale 1ns/1ns
`default_nettype none

module gcr_index (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire gcr_pkg::gcr_index_src_e src,
	input  wire logic                   first_pos,
	input  wire logic                   otpw_flag,
	input  wire logic                   step_pulse,
	output logic                        index_out
);

	logic tog_q;
	logic tog_d;
	logic idx_q;
	logic idx_d;

	always_comb begin
		tog_d = tog_q ^ step_pulse; // [RL10]
		case (src)
			gcr_pkg::GCR_IDX_FIRST_POS: idx_d = first_pos; // [RL9]
			gcr_pkg::GCR_IDX_OTPW:      idx_d = otpw_flag; // [RL9]
			gcr_pkg::GCR_IDX_STEP:      idx_d = tog_q; // [RL10]
			default:                    idx_d = first_pos;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_q <= 1'b0;
			idx_q <= 1'b0;
		end else begin
			tog_q <= tog_d;
			idx_q <= idx_d;
		end
	end

	assign index_out = idx_q;

	step_toggle_a: assert property ( // [RL10]
		@(posedge clk) disable iff (!rst_n)
		step_pulse |=> tog_q != $past(tog_q))
		else $error("Step pulse did not toggle marker");

	step_shown_a: assert property ( // [RL10]
		@(posedge clk) disable iff (!rst_n)
		src == gcr_pkg::GCR_IDX_STEP |=> idx_q == $past(tog_q))
		else $error("Marker not showing step toggle");

endmodule : gcr_index

`default_nettype wire

// ===== rtl/gcr_global_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "gcr_params.svh"

// How it works
// [RL1] All bits reset to zero unless a bit names another default.
// [RL2] Writes use address plus 0x80; reads use the plain address.
// [RL3] Ten bits at 0x00; bit 0 resets to 1, selects reference source.
// [RL4] Bit 1 loads from OTP; internal sense, reference pin pulled low.
// [RL5] Bit 2 loads from OTP; 0 quiet chopper, 1 current chopper.
// [RL6] High chopper pin inverts bit 2 on variants with that pin.
// [RL7] Host enables quiet chopper first time only at standstill.
// [RL8] Bit 3 reverses rotation against the direction input.
// [RL9] Bit 4 picks first microstep position or overtemp warning marker.
// [RL10] Bit 5 makes the marker toggle on each generated step.
// [RL11] Bit 6 set makes the device ignore the power-down pin.
// [RL12] Host using the serial interface sets bit 6.
// [RL13] Bit 7 picks resolution from pins or the register field.
// [RL14] Bit 8 resets to 1, filters steps above 750Hz fullstep.
// [RL15] Bit 9 test mode: analog out on enable pin, driver enabled.
// [RL16] Bits above 9 ignore writes and read as zero.
module gcr_global_config #(
	parameter bit HAS_CHOPPER_PIN = 1'b1,
	parameter int STEP_W          = 20
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              acc_valid,
	input  wire logic [7:0]        acc_addr,
	input  wire logic [31:0]       acc_wdata,
	output logic                   rd_valid,
	output logic      [31:0]       rd_data,
	input  wire logic              otp_load,
	input  wire logic              otp_rsense,
	input  wire logic              otp_chopper,
	input  wire logic              chopper_invert_pin,
	input  wire logic              resolution_select_pin_a,
	input  wire logic              resolution_select_pin_b,
	input  wire logic              pdn_pin_in,
	input  wire logic              dir_pin,
	input  wire logic              active_low_driver_enable,
	input  wire logic              first_pos,
	input  wire logic              otpw_flag,
	input  wire logic              step_pulse,
	input  wire logic [3:0]        mstep_reg_res,
	input  wire logic              fullstep_fast,
	input  wire logic [STEP_W-1:0] step_raw,
	input  wire logic [STEP_W-1:0] step_filt,
	input  wire logic [1:0]        hold_current_field,
	output logic                   use_vref_ref,
	output logic                   internal_sense_en,
	output logic                   vref_pull_low,
	output logic                   current_chopper_select,
	output logic                   quiet_chopper_en,
	output logic                   dir_eff,
	output logic                   index_out,
	output logic                   standstill_req,
	output logic                   res_from_reg,
	output logic      [3:0]        mstep_code,
	output logic                   filter_active,
	output logic      [STEP_W-1:0] step_interval_readout,
	output logic                   test_out_en,
	output logic      [1:0]        test_sel,
	output logic                   enable_pulldown_en,
	output logic                   driver_enabled
);

	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic       wr
	);
		addr_hit = addr == ({wr, `GCR_CFG_ADDR} | 8'h00);
	endfunction : addr_hit

	gcr_pkg::gcr_cfg_t cfg_q;
	gcr_pkg::gcr_cfg_t cfg_d;
	logic              rdv_q;
	logic              rdv_d;
	logic [31:0]       rdd_q;
	logic [31:0]       rdd_d;
	logic              wr_hit;
	logic              rd_hit;

	logic [5:0]        pins_s;
	logic              chop_pin_s;
	logic              ms_a_s;
	logic              ms_b_s;
	logic              pdn_s;
	logic              dir_s;
	logic              enn_s;

	gcr_sync #(
		.WIDTH (6)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({chopper_invert_pin, resolution_select_pin_a,
		            resolution_select_pin_b, pdn_pin_in, dir_pin,
		            active_low_driver_enable}),
		.sync_out (pins_s)
	);

	assign chop_pin_s = pins_s[5];
	assign ms_a_s     = pins_s[4];
	assign ms_b_s     = pins_s[3];
	assign pdn_s      = pins_s[2];
	assign dir_s      = pins_s[1];
	assign enn_s      = pins_s[0];

	// Register access
	assign wr_hit = acc_valid && addr_hit(acc_addr, 1'b1); // [RL2]
	assign rd_hit = acc_valid && addr_hit(acc_addr, 1'b0); // [RL2]

	always_comb begin
		cfg_d = cfg_q;
		// OTP bits land once the trim read completes; a host write wins
		if (otp_load) begin
			cfg_d[`GCR_B_RSENSE] = otp_rsense; // [RL4]
			cfg_d[`GCR_B_CHOP]   = otp_chopper; // [RL5]
		end
		if (wr_hit) begin
			cfg_d = acc_wdata[`GCR_CFG_W-1:0]; // [RL16]
		end
		rdv_d = rd_hit;
		rdd_d = rd_hit ? {22'h0, cfg_q} : 32'h0; // [RL16]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= `GCR_CFG_RESET; // [RL1] [RL3] [RL14]
			rdv_q <= 1'b0;
			rdd_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			rdv_q <= rdv_d;
			rdd_q <= rdd_d;
		end
	end

	assign rd_valid = rdv_q;
	assign rd_data  = rdd_q;

	// Effects of the configuration on the driver
	logic              vref_q;
	logic              vref_d;
	logic              rsns_q;
	logic              rsns_d;
	logic              chop_q;
	logic              chop_d;
	logic              dir_q;
	logic              dir_d;
	logic              stand_q;
	logic              stand_d;
	logic              rsel_q;
	logic              rsel_d;
	logic [3:0]        mcode_q;
	logic [3:0]        mcode_d;
	logic              filt_q;
	logic              filt_d;
	logic [STEP_W-1:0] step_interval_readout_q;
	logic [STEP_W-1:0] step_interval_readout_d;
	logic              test_q;
	logic              test_d;
	logic [1:0]        tsel_q;
	logic [1:0]        tsel_d;
	logic              drv_q;
	logic              drv_d;

	always_comb begin
		vref_d  = cfg_q[`GCR_B_VREF]; // [RL3]
		rsns_d  = cfg_q[`GCR_B_RSENSE]; // [RL4]
		// Pin only counts on variants that bond it out
		chop_d  = cfg_q[`GCR_B_CHOP] ^ (HAS_CHOPPER_PIN & chop_pin_s); // [RL5] [RL6]
		dir_d   = dir_s ^ cfg_q[`GCR_B_SHAFT]; // [RL8]
		// Shared pin carries serial traffic when bit 6 is set
		stand_d = !cfg_q[`GCR_B_PDN_DIS] && pdn_s; // [RL11] [RL12]
		rsel_d  = cfg_q[`GCR_B_MSTEP_REG]; // [RL13]
		mcode_d = rsel_d ? mstep_reg_res : {2'b00, ms_b_s, ms_a_s}; // [RL13]
		filt_d  = cfg_q[`GCR_B_FILT] && fullstep_fast; // [RL14]
		step_interval_readout_d = filt_d ? step_filt : step_raw; // [RL14]
		test_d  = cfg_q[`GCR_B_TEST]; // [RL15]
		tsel_d  = test_d ? hold_current_field : 2'b00; // [RL15]
		drv_d   = test_d || !enn_s; // [RL15]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vref_q  <= 1'b0;
			rsns_q  <= 1'b0;
			chop_q  <= 1'b0;
			dir_q   <= 1'b0;
			stand_q <= 1'b0;
			rsel_q  <= 1'b0;
			mcode_q <= 4'h0;
			filt_q  <= 1'b0;
			step_interval_readout_q <= '0;
			test_q  <= 1'b0;
			tsel_q  <= 2'h0;
			drv_q   <= 1'b0;
		end else begin
			vref_q  <= vref_d;
			rsns_q  <= rsns_d;
			chop_q  <= chop_d;
			dir_q   <= dir_d;
			stand_q <= stand_d;
			rsel_q  <= rsel_d;
			mcode_q <= mcode_d;
			filt_q  <= filt_d;
			step_interval_readout_q <= step_interval_readout_d;
			test_q  <= test_d;
			tsel_q  <= tsel_d;
			drv_q   <= drv_d;
		end
	end

	assign use_vref_ref           = vref_q;
	assign internal_sense_en      = rsns_q;
	assign vref_pull_low          = rsns_q; // [RL4]
	assign current_chopper_select = chop_q;
	// Quiet mode should first come on at standstill; host's duty
	assign quiet_chopper_en       = !chop_q; // [RL5] [RL7]
	assign dir_eff                = dir_q;
	assign standstill_req         = stand_q;
	assign res_from_reg           = rsel_q;
	assign mstep_code             = mcode_q;
	assign filter_active          = filt_q;
	assign step_interval_readout  = step_interval_readout_q;
	assign test_out_en            = test_q;
	assign test_sel               = tsel_q;
	assign enable_pulldown_en     = !test_q; // [RL15]
	assign driver_enabled         = drv_q;

	gcr_pkg::gcr_index_src_e idx_src;

	always_comb begin
		if (cfg_q[`GCR_B_IDX_STEP]) begin
			idx_src = gcr_pkg::GCR_IDX_STEP; // [RL10]
		end else if (cfg_q[`GCR_B_IDX_OTPW]) begin
			idx_src = gcr_pkg::GCR_IDX_OTPW; // [RL9]
		end else begin
			idx_src = gcr_pkg::GCR_IDX_FIRST_POS; // [RL9]
		end
	end

	gcr_index u_index (
		.clk        (clk),
		.rst_n      (rst_n),
		.src        (idx_src),
		.first_pos  (first_pos),
		.otpw_flag  (otpw_flag),
		.step_pulse (step_pulse),
		.index_out  (index_out)
	);

	reset_defaults_a: assert property ( // [RL1]
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> cfg_q == 10'h101)
		else $error("Config reset value wrong");

	write_offset_a: assert property ( // [RL2]
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_addr == 8'h80 |=> cfg_q == $past(acc_wdata[9:0]))
		else $error("Write at 0x80 not stored");

	read_plain_a: assert property ( // [RL2]
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_addr == 8'h00 |=> rd_valid && rd_data[9:0] == $past(cfg_q))
		else $error("Read at 0x00 wrong");

	no_write_read_a: assert property ( // [RL2]
		@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_addr != 8'h80 && !otp_load |=> $stable(cfg_q))
		else $error("Config changed without write");

	upper_zero_a: assert property ( // [RL16]
		@(posedge clk) disable iff (!rst_n)
		rd_valid |-> rd_data[31:10] == 22'h0)
		else $error("Upper read bits not zero");

	otp_load_a: assert property ( // [RL4]
		@(posedge clk) disable iff (!rst_n)
		otp_load && !acc_valid |=> cfg_q[2:1] == {$past(otp_chopper), $past(otp_rsense)})
		else $error("OTP bits not loaded");

	chopper_inv_a: assert property ( // [RL6]
		@(posedge clk) disable iff (!rst_n)
		##1 current_chopper_select == ($past(cfg_q[2]) ^ (HAS_CHOPPER_PIN & $past(chop_pin_s))))
		else $error("Chopper select not inverted by pin");

	dir_invert_a: assert property ( // [RL8]
		@(posedge clk) disable iff (!rst_n)
		##1 dir_eff == ($past(dir_s) ^ $past(cfg_q[3])))
		else $error("Direction not inverted");

	pdn_ignore_a: assert property ( // [RL11]
		@(posedge clk) disable iff (!rst_n)
		cfg_q[6] |=> !standstill_req)
		else $error("Power-down pin not ignored");

	res_source_a: assert property ( // [RL13]
		@(posedge clk) disable iff (!rst_n)
		cfg_q[7] |=> mstep_code == $past(mstep_reg_res))
		else $error("Resolution not from register");

	filter_off_a: assert property ( // [RL14]
		@(posedge clk) disable iff (!rst_n)
		!cfg_q[8] |=> !filter_active && step_interval_readout == $past(step_raw))
		else $error("Filter active while disabled");

	test_enable_a: assert property ( // [RL15]
		@(posedge clk) disable iff (!rst_n)
		cfg_q[9] |=> driver_enabled && !enable_pulldown_en && test_out_en)
		else $error("Test mode effects missing");

	index_otpw_a: assert property ( // [RL9]
		@(posedge clk) disable iff (!rst_n)
		cfg_q[5:4] == 2'b01 |=> index_out == $past(otpw_flag))
		else $error("Marker not showing warning flag");

endmodule : gcr_global_config

`default_nettype wire

// ===== testbench/gcr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the register link; lines it releases show the inverse
module gcr_host_model (
	input  wire logic        clk,
	output logic             acc_valid,
	output logic      [7:0]  acc_addr,
	output logic      [31:0] acc_wdata,
	input  wire logic        rd_valid,
	input  wire logic [31:0] rd_data
);
	initial begin
		acc_valid = 1'b0;
		acc_addr  = 8'h7f;
		acc_wdata = 32'h0;
	end
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_addr  <= a;
		acc_wdata <= d;
		@(posedge clk);
		acc_valid <= 1'b0;
		acc_addr  <= ~a;
		acc_wdata <= ~d;
	endtask : put
	// Writes go to the register address plus 0x80
	task automatic wr(input logic [31:0] d);
		put(8'h80, d);
	endtask : wr
	task automatic rd(output logic v, output logic [31:0] q);
		put(8'h00, 32'h0);
		#1;
		v = rd_valid;
		q = rd_data;
	endtask : rd
endmodule : gcr_host_model
`default_nettype wire

// ===== testbench/test_gcr_global_config.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module test_gcr_global_config;
	logic        clk = 1'b0, rst_n = 1'b0, otp_load = 1'b0, otp_rsense = 1'b0;
	logic        otp_chopper = 1'b0, chopper_invert_pin = 1'b0, pdn_pin_in = 1'b0;
	logic        resolution_select_pin_a = 1'b0, resolution_select_pin_b = 1'b0;
	logic        dir_pin = 1'b0, active_low_driver_enable = 1'b0, first_pos = 1'b0;
	logic        otpw_flag = 1'b0, step_pulse = 1'b0, fullstep_fast = 1'b1;
	logic [3:0]  mstep_reg_res = 4'h5;
	logic [19:0] step_raw = 20'h0aaaa, step_filt = 20'h05555;
	logic [1:0]  hold_current_field = 2'h2;
	logic        acc_valid, rd_valid, use_vref_ref, internal_sense_en, vref_pull_low;
	logic        current_chopper_select, quiet_chopper_en, dir_eff, index_out;
	logic        standstill_req, res_from_reg, filter_active, test_out_en;
	logic        enable_pulldown_en, driver_enabled;
	logic [7:0]  acc_addr;
	logic [31:0] acc_wdata, rd_data;
	logic [3:0]  mstep_code;
	logic [19:0] step_interval_readout;
	logic [1:0]  test_sel;
	int          fails = 0, n_compared = 0;

	always #25 clk = ~clk;

	gcr_host_model host (.clk, .acc_valid, .acc_addr, .acc_wdata, .rd_valid, .rd_data);
	gcr_global_config uut (.clk, .rst_n, .acc_valid, .acc_addr, .acc_wdata, .rd_valid,
		.rd_data, .otp_load, .otp_rsense, .otp_chopper, .chopper_invert_pin,
		.resolution_select_pin_a, .resolution_select_pin_b, .pdn_pin_in, .dir_pin,
		.active_low_driver_enable, .first_pos, .otpw_flag, .step_pulse, .mstep_reg_res,
		.fullstep_fast, .step_raw, .step_filt, .hold_current_field, .use_vref_ref,
		.internal_sense_en, .vref_pull_low, .current_chopper_select, .quiet_chopper_en,
		.dir_eff, .index_out, .standstill_req, .res_from_reg, .mstep_code, .filter_active,
		.step_interval_readout, .test_out_en, .test_sel, .enable_pulldown_en, .driver_enabled);

	// Pins pass two sync flops and an output register
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	task automatic cfg(input logic [31:0] d);
		host.wr(d);
		settle();
	endtask : cfg
	task automatic t_reset;
		logic v;
		logic [31:0] q;
		host.rd(v, q);
		`CHK(v, 1'b1)
		`CHK(q, 32'h101)
		`CHK(use_vref_ref, 1'b1)
		`CHK(enable_pulldown_en, 1'b1)
		`CHK(filter_active, 1'b1)
		`CHK(step_interval_readout, 20'h05555)
	endtask : t_reset
	task automatic t_otp;
		logic v;
		logic [31:0] q;
		@(posedge clk);
		otp_rsense <= 1'b1;
		otp_chopper <= 1'b1;
		otp_load <= 1'b1;
		@(posedge clk);
		otp_load <= 1'b0;
		host.rd(v, q);
		`CHK(q, 32'h107)
		settle();
		`CHK(internal_sense_en, 1'b1)
		`CHK(vref_pull_low, 1'b1)
		`CHK(current_chopper_select, 1'b1)
		`CHK(quiet_chopper_en, 1'b0)
		@(posedge clk);
		chopper_invert_pin <= 1'b1;
		settle();
		`CHK(current_chopper_select, 1'b0)
		`CHK(quiet_chopper_en, 1'b1)
	endtask : t_otp
	task automatic t_access;
		logic v;
		logic [31:0] q;
		host.wr(32'hffff_fc48);
		host.rd(v, q);
		`CHK(q, 32'h048)
		host.put(8'h81, 32'h3ff);
		#1;
		`CHK(rd_valid, 1'b0)
		host.put(8'h00, 32'h3ff);
		host.rd(v, q);
		`CHK(q, 32'h048)
	endtask : t_access
	task automatic t_pins;
		@(posedge clk);
		dir_pin <= 1'b1;
		pdn_pin_in <= 1'b1;
		settle();
		`CHK(dir_eff, 1'b0)
		`CHK(standstill_req, 1'b0)
		cfg(32'h0);
		`CHK(dir_eff, 1'b1)
		`CHK(standstill_req, 1'b1)
	endtask : t_pins
	task automatic t_index;
		logic i0;
		@(posedge clk);
		first_pos <= 1'b1;
		settle();
		`CHK(index_out, 1'b1)
		cfg(32'h10);
		`CHK(index_out, 1'b0)
		cfg(32'h30);
		i0 = index_out;
		repeat (2) begin
			@(posedge clk);
			step_pulse <= 1'b1;
			@(posedge clk);
			step_pulse <= 1'b0;
			settle();
			i0 = ~i0;
			`CHK(index_out, i0)
		end
	endtask : t_index
	task automatic t_misc;
		@(posedge clk);
		resolution_select_pin_a <= 1'b1;
		active_low_driver_enable <= 1'b1;
		cfg(32'h0);
		`CHK(mstep_code, 4'h1)
		`CHK(filter_active, 1'b0)
		`CHK(step_interval_readout, 20'h0aaaa)
		`CHK(driver_enabled, 1'b0)
		`CHK(use_vref_ref, 1'b0)
		`CHK(internal_sense_en, 1'b0)
		`CHK(res_from_reg, 1'b0)
		cfg(32'h380);
		`CHK(mstep_code, 4'h5)
		`CHK(res_from_reg, 1'b1)
		`CHK(step_interval_readout, 20'h05555)
		`CHK(test_out_en, 1'b1)
		`CHK(test_sel, 2'h2)
		`CHK(enable_pulldown_en, 1'b0)
		`CHK(driver_enabled, 1'b1)
		cfg(32'h040);
		`CHK(test_sel, 2'h0)
	endtask : t_misc
	// Mid-run reset must bring back the defaults and drop OTP bits
	task automatic t_rerun;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		t_reset();
	endtask : t_rerun
	task automatic final_report;
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		t_reset();
		t_otp();
		t_access();
		t_pins();
		t_index();
		t_misc();
		t_rerun();
		final_report();
	end
	// Tests need well under 2000 cycles
	initial begin
		#500000;
		fails++;
		final_report();
	end
endmodule : test_gcr_global_config
`default_nettype wire
